// file: verilog/srt_sysreg_trap.sv
// Notes on behaviour
// - Monitor select register: monitor level read/write always; lower levels undefined.
// - Hypervisor select: monitor only non-secure; hypervisor traps to monitor if select&!enable.
// - Secure kernel copy: monitor allowed; secure kernel traps to monitor if select&!enable.
// - Non-secure kernel access: hypervisor trap first, then monitor trap, else allowed.
// - Non-secure kernel copy: monitor always allowed; hypervisor traps to monitor conditionally.
// - No monitor level: single kernel copy, hypervisor allowed, kernel may trap to hypervisor.
// - Unlisted access combinations do not occur; they answer undefined here.
// - Secure own-group write: signal S1, S0 only if security disabled, never NS1.
// - Secure other-group write with affinity: only NS1 targets signalled.
// - Non-secure own-group write: NS1 always, S1 only when permitted.
// - Non-secure other-group write: S1 only when permitted, never NS1.
// - Non-secure write to S0 target: permit or security disable; group0, own group1 and other group1 writes alike.
// - Secure group 1 delivered as group 0 when secure kernel off or disabled.
// - Other-state softints only while affinity routing enabled for both states.
// - Higher select at 0 forces dependent lower select to read zero, ignore writes.
// - Monitor or hypervisor select at 0 makes that level's enable act as 1 except for access.
// - Monitor in 32-bit state turns monitor traps into undefined at current level.
//
// Decided for this implementation: strobed register access and the address map.
`default_nettype none
module srt_sysreg_trap
	import srt_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic ACC_VALID,
	input wire srt_acc_type ACC_REQ,
	output srt_outcome_type ACC_OUTCOME,
	output logic [1:0] ACC_RDATA,
	input wire logic SGI_VALID,
	input wire srt_sgi_type SGI_REQ,
	output logic [SRT_TARGETS-1:0] SGI_SIGNAL,
	output logic [SRT_TARGETS-1:0] SGI_AS_G0,
	output logic IRQ
);
	////////////////////////////////////////////////////////////////////////////
	// State
	logic [3:0] ctrl;
	logic [SRT_EV_W-1:0] status;
	logic [SRT_EV_W-1:0] mask;
	logic [2*SRT_TARGETS-1:0] groups;
	logic [SRT_TARGETS-1:0] permit;
	srt_bits_type mon_raw;
	srt_bits_type hyp_raw;
	srt_bits_type kern_s_raw;
	srt_bits_type kern_ns_raw;

	////////////////////////////////////////////////////////////////////////////
	// Effective select and enable values
	logic mon_exists;
	logic mon_32bit;
	logic sec_disable;
	logic aff_both;
	srt_bits_type mon_eff;
	srt_bits_type hyp_eff;
	srt_bits_type kern_s_eff;
	srt_bits_type kern_ns_eff;
	logic hyp_gate;

	assign mon_exists = ctrl[SRT_CTRL_MON_EXISTS];
	assign mon_32bit = ctrl[SRT_CTRL_MON_32BIT];
	assign sec_disable = ctrl[SRT_CTRL_SEC_DISABLE];
	assign aff_both = ctrl[SRT_CTRL_AFF_BOTH];
	assign mon_eff.sel = mon_raw.sel;
	assign mon_eff.en = mon_raw.en | ~mon_raw.sel;
	assign hyp_gate = ~mon_exists | mon_raw.sel;
	assign hyp_eff.sel = hyp_raw.sel & hyp_gate;
	assign hyp_eff.en = hyp_raw.en | ~hyp_eff.sel;
	assign kern_s_eff.sel = kern_s_raw.sel & mon_raw.sel;
	assign kern_s_eff.en = kern_s_raw.en;
	assign kern_ns_eff.sel = kern_ns_raw.sel & hyp_eff.sel;
	assign kern_ns_eff.en = kern_ns_raw.en;

	////////////////////////////////////////////////////////////////////////////
	// Access decision
	srt_outcome_type outcome;
	logic acc_ok;
	logic acc_wr;
	logic wr_mon;
	logic wr_hyp;
	logic wr_kern_s;
	logic wr_kern_ns;
	logic is_kern_s;
	srt_bits_type wbits;
	srt_bits_type rd_sel;

	srt_access_decide u_decide (
		.acc(ACC_REQ),
		.mon_exists(mon_exists),
		.mon_32bit(mon_32bit),
		.mon_eff(mon_eff),
		.hyp_eff(hyp_eff),
		.outcome(outcome)
	);

	assign ACC_OUTCOME = ACC_VALID ? outcome : SRT_ALLOW;
	assign acc_ok = ACC_VALID & (outcome == SRT_ALLOW);
	assign acc_wr = acc_ok & ACC_REQ.write;
	assign wbits.sel = ACC_REQ.wr_select;
	assign wbits.en = ACC_REQ.wr_enable;
	// Secure copy only exists with a monitor level
	assign is_kern_s = mon_exists & ~ACC_REQ.ns;
	assign wr_mon = acc_wr & (ACC_REQ.regsel == SRT_REG_MON);
	assign wr_hyp = acc_wr & (ACC_REQ.regsel == SRT_REG_HYP);
	assign wr_kern_s = acc_wr & (ACC_REQ.regsel == SRT_REG_KERN) & is_kern_s;
	assign wr_kern_ns = acc_wr & (ACC_REQ.regsel == SRT_REG_KERN) & ~is_kern_s;
	assign rd_sel = (ACC_REQ.regsel == SRT_REG_MON) ? mon_raw :
		(ACC_REQ.regsel == SRT_REG_HYP) ? {hyp_eff.sel, hyp_raw.en} :
		is_kern_s ? kern_s_eff : kern_ns_eff;

	// Writes to a forced-zero select are ignored
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			mon_raw <= SRT_SEL_RESET;
			hyp_raw <= SRT_SEL_RESET;
			kern_s_raw <= SRT_SEL_RESET;
			kern_ns_raw <= SRT_SEL_RESET;
		end else begin
			if (wr_mon) begin
				mon_raw <= wbits;
			end
			if (wr_hyp) begin
				hyp_raw <= {wbits.sel & hyp_gate, wbits.en};
			end
			if (wr_kern_s) begin
				kern_s_raw <= {wbits.sel & mon_raw.sel, wbits.en};
			end
			if (wr_kern_ns) begin
				kern_ns_raw <= {wbits.sel & hyp_eff.sel, wbits.en};
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ACC_RDATA <= 2'h0;
		end else begin
			ACC_RDATA <= (acc_ok & ~ACC_REQ.write) ? {rd_sel.en, rd_sel.sel} : 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Softint routing
	logic [SRT_TARGETS-1:0] route_sig;
	logic [SRT_TARGETS-1:0] route_g0;
	logic sgi_drop;

	srt_sgi_route u_route (
		.sgi(SGI_REQ),
		.groups(groups),
		.permit(permit),
		.sec_disable(sec_disable),
		.aff_both(aff_both),
		.kern_s_sel(kern_s_eff.sel),
		.signal(route_sig),
		.as_group0(route_g0)
	);

	assign sgi_drop = SGI_VALID & ((route_sig ^ SGI_REQ.targets) != '0);

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SGI_SIGNAL <= '0;
			SGI_AS_G0 <= '0;
		end else begin
			SGI_SIGNAL <= SGI_VALID ? route_sig : '0;
			SGI_AS_G0 <= SGI_VALID ? (route_sig & route_g0) : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event status and interrupt
	logic [SRT_EV_W-1:0] events;
	logic [SRT_EV_W-1:0] clr;
	logic [SRT_EV_W-1:0] next_status;

	assign events[SRT_EV_UNDEF] = ACC_VALID & (outcome == SRT_UNDEF);
	assign events[SRT_EV_TRAP_HYP] = ACC_VALID & (outcome == SRT_TRAP_HYP);
	assign events[SRT_EV_TRAP_MON] = ACC_VALID & (outcome == SRT_TRAP_MON);
	assign events[SRT_EV_SGI_DROP] = sgi_drop;
	assign clr = (WR && ADDR == SRT_ADDR_STATUS) ? WDATA[SRT_EV_W-1:0] : '0;
	// Set wins over a simultaneous clear
	assign next_status = (status & ~clr) | events;
	assign IRQ = (status & mask) != '0;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register bus
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl <= SRT_CTRL_RESET;
			mask <= '0;
			groups <= '0;
			permit <= '0;
		end else if (WR) begin
			case (ADDR)
				SRT_ADDR_CTRL: ctrl <= WDATA[3:0];
				SRT_ADDR_MASK: mask <= WDATA[SRT_EV_W-1:0];
				SRT_ADDR_GROUP: groups <= WDATA[2*SRT_TARGETS-1:0];
				SRT_ADDR_PERMIT: permit <= WDATA[SRT_TARGETS-1:0];
				default: ;
			endcase
		end
	end

	logic [31:0] rd_mux;
	logic [7:0] sel_view;

	assign sel_view = {kern_ns_eff.en, kern_ns_eff.sel, kern_s_eff.en, kern_s_eff.sel,
		hyp_raw.en, hyp_eff.sel, mon_raw.en, mon_raw.sel};
	assign rd_mux = (ADDR == SRT_ADDR_CTRL) ? {28'h0, ctrl} :
		(ADDR == SRT_ADDR_STATUS) ? {28'h0, status} :
		(ADDR == SRT_ADDR_MASK) ? {28'h0, mask} :
		(ADDR == SRT_ADDR_GROUP) ? {24'h0, groups} :
		(ADDR == SRT_ADDR_PERMIT) ? {28'h0, permit} :
		(ADDR == SRT_ADDR_SELECT) ? {24'h0, sel_view} : 32'h0;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			RDATA <= 32'h0;
		end else begin
			RDATA <= RD ? rd_mux : 32'h0;
		end
	end
endmodule
`default_nettype wire

// file: verilog/srt_pkg.sv
`default_nettype none
package srt_pkg;
	localparam int unsigned SRT_TARGETS = 4;
	// Exception levels and security state as presented by the core
	localparam logic [1:0] SRT_LVL_KERNEL = 2'h1;
	localparam logic [1:0] SRT_LVL_HYP = 2'h2;
	localparam logic [1:0] SRT_LVL_MON = 2'h3;
	// Interface-select register being accessed
	localparam logic [1:0] SRT_REG_MON = 2'h0;
	localparam logic [1:0] SRT_REG_HYP = 2'h1;
	localparam logic [1:0] SRT_REG_KERN = 2'h2;
	// Softint generation register being written
	localparam logic [1:0] SRT_SGI_OWN_G1 = 2'h0;
	localparam logic [1:0] SRT_SGI_OTHER_G1 = 2'h1;
	localparam logic [1:0] SRT_SGI_G0 = 2'h2;
	// Group configuration of the softint at a target
	localparam logic [1:0] SRT_GRP_S0 = 2'h0;
	localparam logic [1:0] SRT_GRP_S1 = 2'h1;
	localparam logic [1:0] SRT_GRP_NS1 = 2'h2;
	// Register bus map
	localparam logic [7:0] SRT_ADDR_CTRL = 8'h00;
	localparam logic [7:0] SRT_ADDR_STATUS = 8'h04;
	localparam logic [7:0] SRT_ADDR_MASK = 8'h08;
	localparam logic [7:0] SRT_ADDR_GROUP = 8'h0C;
	localparam logic [7:0] SRT_ADDR_PERMIT = 8'h10;
	localparam logic [7:0] SRT_ADDR_SELECT = 8'h14;
	// Control register fields
	localparam int unsigned SRT_CTRL_MON_EXISTS = 0;
	localparam int unsigned SRT_CTRL_MON_32BIT = 1;
	localparam int unsigned SRT_CTRL_SEC_DISABLE = 2;
	localparam int unsigned SRT_CTRL_AFF_BOTH = 3;
	localparam logic [3:0] SRT_CTRL_RESET = 4'h1;
	// Event bits of status and mask
	localparam int unsigned SRT_EV_UNDEF = 0;
	localparam int unsigned SRT_EV_TRAP_HYP = 1;
	localparam int unsigned SRT_EV_TRAP_MON = 2;
	localparam int unsigned SRT_EV_SGI_DROP = 3;
	localparam int unsigned SRT_EV_W = 4;
	// Select register reset value {select, enable}: select off, enable on
	localparam logic [1:0] SRT_SEL_RESET = 2'h1;

	typedef enum logic [1:0] {
		SRT_ALLOW,
		SRT_UNDEF,
		SRT_TRAP_HYP,
		SRT_TRAP_MON
	} srt_outcome_type;

	typedef struct packed {
		logic [1:0] regsel;
		logic [1:0] level;
		logic ns;
		logic write;
		logic wr_enable;
		logic wr_select;
	} srt_acc_type;

	typedef struct packed {
		logic [1:0] kind;
		logic [1:0] level;
		logic ns;
		logic [SRT_TARGETS-1:0] targets;
	} srt_sgi_type;

	typedef struct packed {
		logic sel;
		logic en;
	} srt_bits_type;
endpackage
`default_nettype wire

// file: verilog/srt_access_decide.sv
`default_nettype none
module srt_access_decide
	import srt_pkg::*;
(
	input wire srt_acc_type acc,
	input wire logic mon_exists,
	input wire logic mon_32bit,
	input wire srt_bits_type mon_eff,
	input wire srt_bits_type hyp_eff,
	output srt_outcome_type outcome
);
	logic at_mon;
	logic at_hyp;
	logic at_kern;
	logic mon_trap;
	logic hyp_trap;
	srt_outcome_type mon_out;
	srt_outcome_type res_mon_reg;
	srt_outcome_type res_hyp_reg;
	srt_outcome_type res_kern_reg;
	srt_outcome_type res_kern_noel3;
	srt_outcome_type res_kern_el3;

	assign at_mon = acc.level == SRT_LVL_MON;
	assign at_hyp = acc.level == SRT_LVL_HYP;
	assign at_kern = acc.level == SRT_LVL_KERNEL;
	assign mon_trap = mon_exists & mon_eff.sel & ~mon_eff.en;
	assign hyp_trap = hyp_eff.sel & ~hyp_eff.en;
	assign mon_out = mon_32bit ? SRT_UNDEF : SRT_TRAP_MON;

	assign res_mon_reg = (mon_exists && at_mon) ? SRT_ALLOW : SRT_UNDEF;
	assign res_hyp_reg = !mon_exists ? (at_hyp ? SRT_ALLOW : SRT_UNDEF) :
		at_mon ? (acc.ns ? SRT_ALLOW : SRT_UNDEF) :
		(at_hyp && acc.ns) ? (mon_trap ? mon_out : SRT_ALLOW) : SRT_UNDEF;
	assign res_kern_noel3 = at_hyp ? SRT_ALLOW :
		at_kern ? (hyp_trap ? SRT_TRAP_HYP : SRT_ALLOW) : SRT_UNDEF;
	assign res_kern_el3 = at_mon ? SRT_ALLOW :
		!acc.ns ? (at_kern ? (mon_trap ? mon_out : SRT_ALLOW) : SRT_UNDEF) :
		at_hyp ? (mon_trap ? mon_out : SRT_ALLOW) :
		at_kern ? (hyp_trap ? SRT_TRAP_HYP : mon_trap ? mon_out : SRT_ALLOW) :
		SRT_UNDEF;
	assign res_kern_reg = mon_exists ? res_kern_el3 : res_kern_noel3;
	// One outcome per access
	assign outcome = (acc.regsel == SRT_REG_MON) ? res_mon_reg :
		(acc.regsel == SRT_REG_HYP) ? res_hyp_reg :
		(acc.regsel == SRT_REG_KERN) ? res_kern_reg : SRT_UNDEF;
endmodule
`default_nettype wire

// file: verilog/srt_sgi_route.sv
`default_nettype none
module srt_sgi_route
	import srt_pkg::*;
(
	input wire srt_sgi_type sgi,
	input wire logic [2*SRT_TARGETS-1:0] groups,
	input wire logic [SRT_TARGETS-1:0] permit,
	input wire logic sec_disable,
	input wire logic aff_both,
	input wire logic kern_s_sel,
	output logic [SRT_TARGETS-1:0] signal,
	output logic [SRT_TARGETS-1:0] as_group0
);
	logic s1_as_g0;
	logic own;
	logic other;
	logic g0reg;

	assign s1_as_g0 = ~kern_s_sel | sec_disable;
	assign own = sgi.kind == SRT_SGI_OWN_G1;
	assign other = (sgi.kind == SRT_SGI_OTHER_G1) & aff_both;
	assign g0reg = sgi.kind == SRT_SGI_G0;

	genvar t;
	generate
		for (t = 0; t < SRT_TARGETS; t++) begin : g_tgt
			logic [1:0] grp;
			logic is_s0;
			logic is_s1;
			logic is_ns1;
			logic sec_ok;
			logic ns_ok;
			assign grp = groups[2*t +: 2];
			assign is_s0 = grp == SRT_GRP_S0;
			assign is_s1 = grp == SRT_GRP_S1;
			assign is_ns1 = grp == SRT_GRP_NS1;
			assign sec_ok = (own & ((is_s0 & sec_disable) | is_s1)) |
				(other & is_ns1) |
				(g0reg & is_s0);
			assign ns_ok = (own & (is_ns1 | (is_s1 & permit[t]))) |
				(other & is_s1 & permit[t]) |
				((own | other | g0reg) & is_s0 & (permit[t] | sec_disable));
			assign signal[t] = sgi.targets[t] & (sgi.ns ? ns_ok : sec_ok);
			assign as_group0[t] = is_s0 | (is_s1 & s1_as_g0);
		end
	endgenerate
endmodule
`default_nettype wire

// file: sim/srt_checker.sv
`default_nettype none
module srt_checker
	import srt_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic ACC_VALID,
	input wire srt_acc_type ACC_REQ,
	input wire srt_outcome_type ACC_OUTCOME,
	input wire logic [1:0] ACC_RDATA,
	input wire logic SGI_VALID,
	input wire srt_sgi_type SGI_REQ,
	input wire logic [SRT_TARGETS-1:0] SGI_SIGNAL,
	input wire logic [SRT_TARGETS-1:0] SGI_AS_G0
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	////////////////////////////////////////
	chk_idle_allow:
	assert property (!ACC_VALID |-> ACC_OUTCOME == SRT_ALLOW)
		else $error("outcome not allow while idle");
	chk_mon_reg:
	assert property (ACC_VALID && ACC_REQ.regsel == SRT_REG_MON |-> ACC_OUTCOME ==
		(ACC_REQ.level == SRT_LVL_MON ? SRT_ALLOW : SRT_UNDEF))
		else $error("monitor select access outcome wrong");
	chk_hyp_reg_kern:
	assert property (ACC_VALID && ACC_REQ.regsel == SRT_REG_HYP &&
		ACC_REQ.level == SRT_LVL_KERNEL |-> ACC_OUTCOME == SRT_UNDEF)
		else $error("kernel access to hyp select not undefined");
	chk_mon_no_trap:
	assert property (ACC_VALID && ACC_REQ.level == SRT_LVL_MON |->
		ACC_OUTCOME inside {SRT_ALLOW, SRT_UNDEF})
		else $error("monitor level access trapped");
	chk_hyp_trap_src:
	assert property (ACC_OUTCOME == SRT_TRAP_HYP |-> ACC_VALID &&
		ACC_REQ.level == SRT_LVL_KERNEL && ACC_REQ.regsel == SRT_REG_KERN)
		else $error("trap to hyp from wrong access");
	chk_acc_rd_idle:
	assert property (!(ACC_VALID && !ACC_REQ.write && ACC_OUTCOME == SRT_ALLOW)
		|=> ACC_RDATA == 2'h0)
		else $error("select read data without allowed read");
	chk_sgi_quiet:
	assert property (!SGI_VALID |=> SGI_SIGNAL == '0 && SGI_AS_G0 == '0)
		else $error("softint signalled without write");
	chk_sgi_targets:
	assert property (SGI_VALID |=> (SGI_SIGNAL & ~$past(SGI_REQ.targets)) == '0)
		else $error("softint signalled to unnamed target");
	chk_g0_subset:
	assert property ((SGI_AS_G0 & ~SGI_SIGNAL) == '0)
		else $error("group 0 delivery without signal");
	chk_rdata_idle:
	assert property (!RD |=> RDATA == 32'h0)
		else $error("read data without read strobe");
endmodule
`default_nettype wire

// file: sim/srt_core_model.sv
`default_nettype none
module srt_core_model
	import srt_pkg::*;
(
	input wire logic sys_clk,
	output logic acc_valid,
	output srt_acc_type acc_req,
	input wire srt_outcome_type acc_outcome,
	input wire logic [1:0] acc_rdata,
	output logic sgi_valid,
	output srt_sgi_type sgi_req,
	input wire logic [SRT_TARGETS-1:0] sgi_signal,
	input wire logic [SRT_TARGETS-1:0] sgi_as_g0
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		acc_valid = 1'b0;
		acc_req = '0;
		sgi_valid = 1'b0;
		sgi_req = '0;
	end
	// Released request lines toggle
	task automatic access(input logic [1:0] rs, lv, input logic [3:0] f,
		output srt_outcome_type out, output logic [1:0] rdv);
		@(posedge sys_clk);
		acc_valid <= 1'b1;
		acc_req <= srt_acc_type'{rs, lv, f[3], f[2], f[1], f[0]};
		#1 out = acc_outcome;
		@(posedge sys_clk);
		acc_valid <= 1'b0;
		acc_req <= ~acc_req;
		#1 rdv = acc_rdata;
	endtask
	task automatic softint(input logic ns, input logic [1:0] kind,
		output logic [SRT_TARGETS-1:0] sig, g0);
		@(posedge sys_clk);
		sgi_valid <= 1'b1;
		sgi_req <= srt_sgi_type'{kind, ns ? SRT_LVL_KERNEL : SRT_LVL_MON, ns, 4'hF};
		@(posedge sys_clk);
		sgi_valid <= 1'b0;
		sgi_req <= ~sgi_req;
		#1 sig = sgi_signal;
		g0 = sgi_as_g0;
	endtask
endmodule
`default_nettype wire

// file: sim/srt_testbench.sv
`default_nettype none
module testbench
	import srt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, rst, wr, rd, irq, acc_valid, sgi_valid;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [1:0] acc_rdata, rdv;
	logic [3:0] sig, g0, sgi_signal, sgi_as_g0;
	srt_acc_type acc_req;
	srt_sgi_type sgi_req;
	srt_outcome_type acc_outcome, got;
	int num_errors = 0;
	int comparisons = 0;
	srt_sysreg_trap dut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .ACC_VALID(acc_valid), .ACC_REQ(acc_req),
		.ACC_OUTCOME(acc_outcome), .ACC_RDATA(acc_rdata), .SGI_VALID(sgi_valid),
		.SGI_REQ(sgi_req), .SGI_SIGNAL(sgi_signal), .SGI_AS_G0(sgi_as_g0), .IRQ(irq));
	srt_core_model core (.sys_clk(sys_clk), .acc_valid(acc_valid), .acc_req(acc_req),
		.acc_outcome(acc_outcome), .acc_rdata(acc_rdata), .sgi_valid(sgi_valid),
		.sgi_req(sgi_req), .sgi_signal(sgi_signal), .sgi_as_g0(sgi_as_g0));
	always #50 sys_clk = ~sys_clk;
	////////////////////////////////////////
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check_val(input string n, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic check_out(input srt_outcome_type e, g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] outcome expected %0d seen %0d", e, g);
		end
	endtask
	task automatic do_reset;
		if (!rst) begin
			@(posedge sys_clk);
		end
		rst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 check_val(n, e, rdata);
	endtask
	// Flags are {world, write, enable, select}
	task automatic acc(input logic [1:0] rs, lv, input logic [3:0] f, input srt_outcome_type e);
		core.access(rs, lv, f, got, rdv);
		check_out(e, got);
	endtask
	task automatic sgi(input logic ns, input logic [1:0] k, input logic [3:0] es, eg, input bit cg);
		core.softint(ns, k, sig, g0);
		check_val("signal", {28'h0, es}, {28'h0, sig});
		if (cg) check_val("as_group0", {28'h0, eg}, {28'h0, g0});
	endtask
	////////////////////////////////////////
	task automatic t_regs;
		rd_chk("ctrl", SRT_ADDR_CTRL, 32'h1);
		wr_reg(SRT_ADDR_SELECT, 32'h0);
		rd_chk("select", SRT_ADDR_SELECT, 32'hAA);
		wr_reg(8'h40, 32'hFFFF_FFFF);
		rd_chk("unmapped", 8'h40, 32'h0);
	endtask
	task automatic t_select;
		acc(SRT_REG_MON, SRT_LVL_HYP, 4'h8, SRT_UNDEF);
		acc(SRT_REG_MON, SRT_LVL_KERNEL, 4'h0, SRT_UNDEF);
		acc(SRT_REG_MON, SRT_LVL_MON, 4'h5, SRT_ALLOW);
		acc(SRT_REG_MON, SRT_LVL_MON, 4'h0, SRT_ALLOW);
		check_val("mon_read", 32'h1, {30'h0, rdv});
		acc(SRT_REG_HYP, SRT_LVL_MON, 4'h0, SRT_UNDEF);
		acc(SRT_REG_HYP, SRT_LVL_KERNEL, 4'h8, SRT_UNDEF);
		acc(SRT_REG_HYP, SRT_LVL_HYP, 4'h8, SRT_TRAP_MON);
		acc(SRT_REG_HYP, SRT_LVL_MON, 4'hD, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_KERNEL, 4'h0, SRT_TRAP_MON);
		acc(SRT_REG_KERN, SRT_LVL_MON, 4'h0, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_MON, 4'h8, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_HYP, 4'h8, SRT_TRAP_MON);
		acc(SRT_REG_KERN, SRT_LVL_KERNEL, 4'h8, SRT_TRAP_HYP);
		wr_reg(SRT_ADDR_CTRL, 32'h3);
		acc(SRT_REG_HYP, SRT_LVL_HYP, 4'h8, SRT_UNDEF);
		wr_reg(SRT_ADDR_CTRL, 32'h1);
		acc(SRT_REG_HYP, SRT_LVL_MON, 4'hF, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_KERNEL, 4'h8, SRT_TRAP_MON);
		acc(SRT_REG_MON, SRT_LVL_MON, 4'h7, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_KERNEL, 4'hF, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_KERNEL, 4'h8, SRT_ALLOW);
		check_val("kns_read", 32'h3, {30'h0, rdv});
		acc(SRT_REG_HYP, SRT_LVL_MON, 4'hC, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_KERNEL, 4'h8, SRT_ALLOW);
		check_val("kns_forced", 32'h2, {30'h0, rdv});
		rd_chk("acc_status", SRT_ADDR_STATUS, 32'h7);
	endtask
	task automatic t_no_mon;
		wr_reg(SRT_ADDR_CTRL, 32'h0);
		acc(SRT_REG_HYP, SRT_LVL_HYP, 4'hD, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_KERNEL, 4'h8, SRT_TRAP_HYP);
		acc(SRT_REG_KERN, SRT_LVL_HYP, 4'hF, SRT_ALLOW);
		acc(SRT_REG_HYP, SRT_LVL_HYP, 4'hE, SRT_ALLOW);
		acc(SRT_REG_KERN, SRT_LVL_KERNEL, 4'h8, SRT_ALLOW);
		check_val("single_read", 32'h2, {30'h0, rdv});
	endtask
	// Targets: 0 secure g0, 1 secure g1, 2 non-secure g1, 3 secure g1 permitted
	task automatic t_sgi;
		wr_reg(SRT_ADDR_GROUP, 32'h64);
		wr_reg(SRT_ADDR_PERMIT, 32'h8);
		wr_reg(SRT_ADDR_CTRL, 32'h9);
		sgi(1'b0, SRT_SGI_OWN_G1, 4'hA, 4'hA, 1);
		sgi(1'b0, SRT_SGI_OTHER_G1, 4'h4, 4'h0, 1);
		sgi(1'b1, SRT_SGI_OWN_G1, 4'hC, 4'h8, 1);
		sgi(1'b1, SRT_SGI_OTHER_G1, 4'h8, 4'h8, 1);
		sgi(1'b1, SRT_SGI_G0, 4'h0, 4'h0, 1);
		rd_chk("status", SRT_ADDR_STATUS, 32'h8);
		wr_reg(SRT_ADDR_CTRL, 32'hD);
		sgi(1'b0, SRT_SGI_OWN_G1, 4'hB, 4'h0, 0);
		sgi(1'b1, SRT_SGI_G0, 4'h1, 4'h0, 0);
		sgi(1'b1, SRT_SGI_OTHER_G1, 4'h9, 4'h0, 0);
		wr_reg(SRT_ADDR_CTRL, 32'h1);
		sgi(1'b0, SRT_SGI_OTHER_G1, 4'h0, 4'h0, 1);
		sgi(1'b1, SRT_SGI_OTHER_G1, 4'h0, 4'h0, 1);
	endtask
	task automatic t_irq;
		acc(SRT_REG_MON, SRT_LVL_KERNEL, 4'h0, SRT_UNDEF);
		rd_chk("status", SRT_ADDR_STATUS, 32'h1);
		check_val("irq_masked", 32'h0, {31'h0, irq});
		wr_reg(SRT_ADDR_MASK, 32'h1);
		#1 check_val("irq_set", 32'h1, {31'h0, irq});
		wr_reg(SRT_ADDR_STATUS, 32'h1);
		#1 check_val("irq_clear", 32'h0, {31'h0, irq});
		rd_chk("status", SRT_ADDR_STATUS, 32'h0);
	endtask
	////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		do_reset;
		t_regs;
		t_select;
		do_reset;
		t_no_mon;
		do_reset;
		t_sgi;
		do_reset;
		t_irq;
		final_report;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		$display("[ERR] run expected done seen running");
		final_report;
	end
endmodule
bind srt_sysreg_trap srt_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .RD(RD), .RDATA(RDATA),
	.ACC_VALID(ACC_VALID), .ACC_REQ(ACC_REQ), .ACC_OUTCOME(ACC_OUTCOME),
	.ACC_RDATA(ACC_RDATA), .SGI_VALID(SGI_VALID), .SGI_REQ(SGI_REQ),
	.SGI_SIGNAL(SGI_SIGNAL), .SGI_AS_G0(SGI_AS_G0));
`default_nettype wire
